// file: rtl/tio_term_io_setup.sv
// Termination and I/O pin setup register with pin function and driver control.
`timescale 1ns/1ps
`include "tio_consts.svh"

module tio_term_io_setup (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Register write port from the serial interface decoder.
	input wire logic wrStrobe,
	input wire logic [4:0] wrAddr,
	input wire logic [7:0] wrData,
	input wire logic initMode,
	// Device conditions.
	input wire logic lowPowerMode,
	input wire logic cyclicSense,
	input wire logic cyclicActive,
	input wire logic overVoltage,
	// Requested I/O zero and I/O one drive from normal operation.
	input wire logic io0HighReq,
	input wire logic io0LowReq,
	input wire logic io1HighReq,
	input wire logic io1LowReq,
	// Register readback and decoded pin functions.
	output logic [7:0] setupValue,
	output tio_pkg::tio_func_t termPinOneFunction,
	output tio_pkg::tio_func_t term_pin_two_function,
	output logic termMasterSwitch,
	// Driver controls.
	output logic io0HighSide,
	output logic io0LowSide,
	output logic io1HighSide,
	output logic io1LowSide
);
	import tio_pkg::*;

	typedef struct packed {
		logic [7:0] setup;
		logic [2:0] ovSync;
		logic ovFilt;
		tio_cyc_t cyc;
		logic savedHigh;
		logic savedLow;
		logic io0H;
		logic io0L;
		logic io1H;
		logic io1L;
		tio_func_t f1;
		tio_func_t f2;
		logic master;
	} tio_state_t;

	tio_state_t cur;
	tio_state_t next_cur;
	logic ovStable;

	// Field two has no master termination use, so a reserved code is treated as off.
	function automatic tio_func_t decodeTwo(input logic [1:0] f);
		decodeTwo = (f == 2'h2) ? TIO_PIN_GPIO : TIO_PIN_OFF;
	endfunction : decodeTwo

	function automatic tio_func_t decodeOne(input logic [1:0] f);
		case (f)
			2'h1: decodeOne = TIO_PIN_MASTER_TERM;
			2'h2: decodeOne = TIO_PIN_GPIO;
			default: decodeOne = TIO_PIN_OFF;
		endcase
	endfunction : decodeOne

	// An overvoltage change counts only once the second and third stages agree.
	// Holding the last agreed level keeps a bouncing input from toggling I/O one.
	assign ovStable = (cur.ovSync[2] == cur.ovSync[1]) ? cur.ovSync[1] : cur.ovFilt;

	always_comb begin
		next_cur = cur;
		next_cur.ovSync = {cur.ovSync[1:0], overVoltage};
		next_cur.ovFilt = ovStable;
		if (wrStrobe && wrAddr == `TIO_SETUP_ADDR && initMode) begin
			next_cur.setup = wrData;
		end
		next_cur.f1 = decodeOne(cur.setup[`TIO_BIT_T1_HI:`TIO_BIT_T1_LO]);
		next_cur.f2 = decodeTwo(cur.setup[`TIO_BIT_T2_HI:`TIO_BIT_T2_LO]);
		next_cur.master = (decodeOne(cur.setup[`TIO_BIT_T1_HI:`TIO_BIT_T1_LO])
			== TIO_PIN_MASTER_TERM);
		case (cur.cyc)
			TIO_CS_NORMAL: begin
				if (lowPowerMode && cyclicSense) begin
					next_cur.cyc = cyclicActive ? TIO_CS_ACTIVE : TIO_CS_OFF;
				end else begin
					next_cur.savedHigh = io0HighReq;
					next_cur.savedLow = io0LowReq;
				end
			end
			TIO_CS_ACTIVE, TIO_CS_OFF: begin
				if (!(lowPowerMode && cyclicSense)) begin
					next_cur.cyc = TIO_CS_NORMAL;
				end else begin
					next_cur.cyc = cyclicActive ? TIO_CS_ACTIVE : TIO_CS_OFF;
				end
			end
			default: next_cur.cyc = TIO_CS_NORMAL;
		endcase
		// I/O zero drive.
		// A double request drives neither side, so the pin can never shoot through.
		if (!cur.setup[`TIO_BIT_IO0_EN]) begin
			next_cur.io0H = 1'h0;
			next_cur.io0L = 1'h0;
		end else if (cur.cyc == TIO_CS_NORMAL) begin
			next_cur.io0H = io0HighReq & ~io0LowReq;
			next_cur.io0L = io0LowReq & ~io0HighReq;
		end else if (cur.cyc == TIO_CS_ACTIVE) begin
			next_cur.io0H = cur.savedHigh & ~cur.savedLow;
			next_cur.io0L = cur.savedLow & ~cur.savedHigh;
		end else if (cur.setup[`TIO_BIT_CYC_INV]) begin
			next_cur.io0H = cur.savedLow & ~cur.savedHigh;
			next_cur.io0L = cur.savedHigh & ~cur.savedLow;
		end else begin
			next_cur.io0H = 1'h0;
			next_cur.io0L = 1'h0;
		end
		// I/O one drive; overvoltage shut-off overrides the request.
		if (!cur.setup[`TIO_BIT_IO1_EN]) begin
			next_cur.io1H = 1'h0;
			next_cur.io1L = 1'h0;
		end else if (cur.setup[`TIO_BIT_OVOFF] && ovStable) begin
			next_cur.io1H = 1'h0;
			next_cur.io1L = 1'h0;
		end else begin
			next_cur.io1H = io1HighReq & ~io1LowReq;
			next_cur.io1L = io1LowReq & ~io1HighReq;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cur <= '{setup: `TIO_SETUP_RESET, ovSync: 3'h0, cyc: TIO_CS_NORMAL,
				f1: TIO_PIN_OFF, f2: TIO_PIN_OFF, default: 1'h0};
		end else begin
			cur <= next_cur;
		end
	end

	assign setupValue = cur.setup;
	assign termPinOneFunction = cur.f1;
	assign term_pin_two_function = cur.f2;
	assign termMasterSwitch = cur.master;
	assign io0HighSide = cur.io0H;
	assign io0LowSide = cur.io0L;
	assign io1HighSide = cur.io1H;
	assign io1LowSide = cur.io1L;

	ignore_outside_init_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!initMode |=> $stable(setupValue))
		else $error("Setup register changed outside initialization mode.");

	write_in_init_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrStrobe && initMode && wrAddr == `TIO_SETUP_ADDR |=> setupValue == $past(wrData))
		else $error("Write in initialization mode not stored.");

	ov_shutoff_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(setupValue[`TIO_BIT_OVOFF] && overVoltage) [*4] |=> !io1HighSide && !io1LowSide)
		else $error("I/O one not off during overvoltage.");

	pin_two_decode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$stable(setupValue) |-> term_pin_two_function ==
		(setupValue[6:5] == 2'h2 ? TIO_PIN_GPIO : TIO_PIN_OFF))
		else $error("Pin two function decoded wrongly.");

	pin_one_master_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$stable(setupValue) |-> termMasterSwitch ==
		(setupValue[`TIO_BIT_T1_HI:`TIO_BIT_T1_LO] == 2'h1))
		else $error("Master termination switch decoded wrongly.");

	io1_disabled_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!setupValue[2] && $stable(setupValue) |=> !io1HighSide && !io1LowSide)
		else $error("I/O one driven while disabled.");

	io0_disabled_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!setupValue[1] && $stable(setupValue) |=> !io0HighSide && !io0LowSide)
		else $error("I/O zero driven while disabled.");

	cyc_off_time_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cur.cyc == TIO_CS_OFF && !setupValue[0] && $stable(setupValue)
		|=> !io0HighSide && !io0LowSide)
		else $error("I/O zero driven in cyclic off time.");

	cyc_opposite_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cur.cyc == TIO_CS_OFF && setupValue[1:0] == 2'h3 && $stable(setupValue)
		&& cur.savedHigh && !cur.savedLow |=> io0LowSide && !io0HighSide)
		else $error("Opposite driver not turned on in cyclic off time.");

	pin_one_func_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$stable(setupValue) |-> termPinOneFunction ==
		(setupValue[4:3] == 2'h1 ? TIO_PIN_MASTER_TERM :
		setupValue[4:3] == 2'h2 ? TIO_PIN_GPIO : TIO_PIN_OFF))
		else $error("Pin one function decoded wrongly.");

	io0_enabled_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		setupValue[`TIO_BIT_IO0_EN] && cur.cyc == TIO_CS_NORMAL && io0HighReq && !io0LowReq
		|=> io0HighSide && !io0LowSide)
		else $error("I/O zero high side not driven while enabled.");

	ov_kept_on_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!setupValue[`TIO_BIT_OVOFF] && setupValue[`TIO_BIT_IO1_EN] && io1LowReq && !io1HighReq
		|=> io1LowSide && !io1HighSide)
		else $error("I/O one turned off although shut-off is not selected.");

	io0_restore_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cur.cyc == TIO_CS_ACTIVE && setupValue[`TIO_BIT_IO0_EN]
		&& cur.savedHigh && !cur.savedLow |=> io0HighSide && !io0LowSide)
		else $error("I/O zero state not restored in cyclic active time.");

	cyc_opposite_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cur.cyc == TIO_CS_OFF && setupValue[1:0] == 2'h3 && $stable(setupValue)
		&& cur.savedLow && !cur.savedHigh |=> io0HighSide && !io0LowSide)
		else $error("High side not turned on in cyclic off time.");
endmodule : tio_term_io_setup

// file: shared/tio_consts.svh
// Offsets, field positions and reset values of the termination and I/O pin setup register.
`ifndef TIO_CONSTS_SVH
`define TIO_CONSTS_SVH
`define TIO_SETUP_ADDR 5'h07
`define TIO_SETUP_RESET 8'h00
`define TIO_BIT_OVOFF 7
`define TIO_BIT_T2_HI 6
`define TIO_BIT_T2_LO 5
`define TIO_BIT_T1_HI 4
`define TIO_BIT_T1_LO 3
`define TIO_BIT_IO1_EN 2
`define TIO_BIT_IO0_EN 1
`define TIO_BIT_CYC_INV 0
`endif

// file: shared/tio_pkg.sv
// Types shared by the termination and I/O pin setup block.
package tio_pkg;
	typedef enum logic [1:0] {
		TIO_PIN_OFF = 2'h0,
		TIO_PIN_MASTER_TERM = 2'h1,
		TIO_PIN_GPIO = 2'h2,
		TIO_PIN_NA = 2'h3
	} tio_func_t;
	typedef enum logic [2:0] {
		TIO_CS_NORMAL = 3'h1,
		TIO_CS_ACTIVE = 3'h2,
		TIO_CS_OFF = 3'h4
	} tio_cyc_t;
endpackage : tio_pkg

// file: test/tio_host.sv
// Host model that writes the setup register through the decoded write port.
`timescale 1ns/1ps
`include "tio_consts.svh"
module tio_host (
	// Clock.
	input wire logic core_clk,
	// Write port toward the device.
	output logic wrStrobe,
	output logic [4:0] wrAddr,
	output logic [7:0] wrData
);
	initial begin
		wrStrobe = 1'h0;
		wrAddr = 5'h00;
		wrData = 8'h00;
	end
	// Lines are inverted after the edge so a stale byte can never be taken twice.
	task automatic write(input logic [4:0] a, input logic [7:0] d);
		// The reserved pin two code is never sent; it falls back to pin off.
		if (a == `TIO_SETUP_ADDR && d[`TIO_BIT_T2_HI:`TIO_BIT_T2_LO] == 2'h1) begin
			d[`TIO_BIT_T2_HI:`TIO_BIT_T2_LO] = 2'h0;
		end
		@(posedge core_clk) #1;
		wrStrobe = 1'h1;
		wrAddr = a;
		wrData = d;
		@(posedge core_clk) #1;
		wrStrobe = 1'h0;
		wrAddr = ~a;
		wrData = ~d;
	endtask : write
endmodule : tio_host

// file: test/tb.sv
// Self-checking bench for the termination and I/O pin setup register.
`timescale 1ns/1ps
module tb;
	import tio_pkg::*;
	logic core_clk = 1'h0;
	logic rst_n = 1'h0;
	logic initMode = 1'h1;
	logic lowPowerMode = 1'h0, cyclicSense = 1'h0, cyclicActive = 1'h0, overVoltage = 1'h0;
	logic io0HighReq = 1'h0, io0LowReq = 1'h0, io1HighReq = 1'h0, io1LowReq = 1'h0;
	logic wrStrobe, termMasterSwitch, io0HighSide, io0LowSide, io1HighSide, io1LowSide;
	logic [4:0] wrAddr;
	logic [7:0] wrData, setupValue;
	tio_func_t termPinOneFunction, term_pin_two_function;
	int miscompares = 0;
	int cmp_count = 0;
	always #5 core_clk = ~core_clk;
	tio_host host (.core_clk(core_clk), .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData));
	tio_term_io_setup dut (.core_clk(core_clk), .rst_n(rst_n), .wrStrobe(wrStrobe),
		.wrAddr(wrAddr), .wrData(wrData), .initMode(initMode), .lowPowerMode(lowPowerMode),
		.cyclicSense(cyclicSense), .cyclicActive(cyclicActive), .overVoltage(overVoltage),
		.io0HighReq(io0HighReq), .io0LowReq(io0LowReq), .io1HighReq(io1HighReq),
		.io1LowReq(io1LowReq), .setupValue(setupValue), .termPinOneFunction(termPinOneFunction),
		.term_pin_two_function(term_pin_two_function), .termMasterSwitch(termMasterSwitch),
		.io0HighSide(io0HighSide), .io0LowSide(io0LowSide), .io1HighSide(io1HighSide),
		.io1LowSide(io1LowSide));
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		host.write(a, d);
		tick(2);
	endtask : wr
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude
	initial begin
		tick(10);
		rst_n = 1'h1;
		chk(setupValue, 8'h00);
		$display("test reset done");
		for (int t = 0; t < 4; t++) begin
			wr(5'h07, {1'h0, (t == 0) ? 2'h0 : (t == 3) ? 2'h3 : 2'h2, 2'(t), 3'h0});
			chk(termPinOneFunction, (t == 3) ? 8'h00 : 8'(t));
			chk(term_pin_two_function, (t == 1 || t == 2) ? 8'h02 : 8'h00);
			chk(termMasterSwitch, 8'(t == 1));
		end
		$display("test decode done");
		wr(5'h07, 8'h06);
		chk(setupValue, 8'h06);
		initMode = 1'h0;
		wr(5'h07, 8'h81);
		chk(setupValue, 8'h06);
		initMode = 1'h1;
		wr(5'h08, 8'h81);
		chk(setupValue, 8'h06);
		$display("test refusal done");
		io0HighReq = 1'h1;
		io1LowReq = 1'h1;
		tick(2);
		chk({io0HighSide, io0LowSide, io1HighSide, io1LowSide}, 8'h9);
		io0LowReq = 1'h1;
		tick(2);
		chk({io0HighSide, io0LowSide}, 8'h0);
		io0LowReq = 1'h0;
		wr(5'h07, 8'h00);
		chk({io0HighSide, io0LowSide, io1HighSide, io1LowSide}, 8'h0);
		$display("test drivers done");
		wr(5'h07, 8'h84);
		chk({io1HighSide, io1LowSide}, 8'h1);
		overVoltage = 1'h1;
		tick(6);
		chk({io1HighSide, io1LowSide}, 8'h0);
		wr(5'h07, 8'h04);
		tick(6);
		chk({io1HighSide, io1LowSide}, 8'h1);
		overVoltage = 1'h0;
		$display("test overvoltage done");
		for (int b = 0; b < 4; b++) begin
			lowPowerMode = 1'h0;
			io0HighReq = (b < 2);
			io0LowReq = (b >= 2);
			wr(5'h07, 8'h02 | 8'(b & 1));
			lowPowerMode = 1'h1;
			cyclicSense = 1'h1;
			cyclicActive = 1'h1;
			tick(3);
			chk({io0HighSide, io0LowSide}, (b < 2) ? 8'h2 : 8'h1);
			cyclicActive = 1'h0;
			tick(3);
			chk({io0HighSide, io0LowSide}, (b == 1) ? 8'h1 : (b == 3) ? 8'h2 : 8'h0);
		end
		lowPowerMode = 1'h0;
		cyclicSense = 1'h0;
		$display("test cyclic done");
		rst_n = 1'h0;
		tick(2);
		rst_n = 1'h1;
		chk(setupValue, 8'h00);
		chk({io0HighSide, io0LowSide, io1HighSide, io1LowSide}, 8'h0);
		$display("test second reset done");
		conclude();
	end
endmodule : tb
